// File: design/vcfg_pkg.sv
// Constants, register map and field layout of the voltage and test-chip initialisation register bank.
// Assumes a single 20 MHz bus clock and an AHB-Lite master issuing single word transfers.
package vcfg_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [31:0] WRITE_GUARD_KEY_ADDR = 32'h1000_0014; // Lock register
  localparam logic [31:0] TEST_CHIP_INIT_CONFIG_ADDR = 32'h1000_0024;
  localparam logic [31:0] CORE_RUN_VOLTAGE_CTRL_ADDR = 32'h1000_0080;
  localparam logic [31:0] CACHE_RUN_VOLTAGE_CTRL_ADDR = 32'h1000_0084;
  localparam logic [31:0] CORE_SLEEP_VOLTAGE_CTRL_ADDR = 32'h1000_0088;
  localparam logic [31:0] CACHE_SLEEP_VOLTAGE_CTRL_ADDR = 32'h1000_008c;

  // ****************************************************************
  // Lock register
  // ****************************************************************
  localparam logic [15:0] GUARD_UNLOCK_KEY = 16'ha05f; // Only value that opens the bank
  localparam logic [15:0] GUARD_KEY_RESET = 16'h0000;  // Bank starts locked
  localparam int GUARD_LOCKED_BIT = 16;

  // ****************************************************************
  // Voltage register fields and scaling
  // ****************************************************************
  localparam int DAC_LSB = 0;   // DAC code in [7:0]
  localparam int ADC_LSB = 8;   // ADC sample in [15:8]
  localparam logic [7:0] DAC_CODE_RESET = 8'h80;      // Centre code, 0.972 V target
  localparam logic [7:0] DAC_MID_CODE = 8'h80;
  localparam int DAC_BASE_UV = 972000;   // Target at mid code
  localparam int DAC_STEP_UV = 4710;     // Microvolts drop per code above mid
  localparam int ADC_RAIL_LSB_UV = 16000; // Halved rails
  localparam int ADC_1V8_LSB_UV = 8000;   // Undivided 1.8 V rail

  // ****************************************************************
  // Initialisation register fields
  // ****************************************************************
  localparam int XFER_LSB = 14;  // Transfer timing [15:14]
  localparam int CLKSRC_LSB = 8; // Clock source [11:8]
  localparam int RATIO_LSB = 4;  // Bus ratio [5:4]
  localparam logic [3:0] CLKSRC_PLL = 4'h0;
  localparam logic [3:0] CLKSRC_BYPASS = 4'h3;
  localparam logic [3:0] CLKSRC_RESET = 4'h3;
  localparam logic [1:0] RATIO_RESET = 2'h0;

  // Moments at which the clock source field reaches the test chip
  typedef enum logic [1:0] {
    XFER_BUS_CLK = 2'b00,
    XFER_NEXT_RESET = 2'b01,
    XFER_PLL_RISE = 2'b10,
    XFER_PLL_FALL = 2'b11
  } xfer_mode_t;

  // ****************************************************************
  // AHB encodings
  // ****************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : vcfg_pkg

// File: design/voltage_and_init_config_regs.sv
// Voltage DAC code registers with ADC readback, polarity protection and a write-locked
// test-chip initialisation register, as an AHB-Lite slave.
// Assumes ADC samples, the PLL input clock and the reset event arrive asynchronously from pins.
//
// Operation
// - Four registers hold 8-bit regulator DAC codes
// - Run registers upper byte reads rail ADC
// - Core sleep upper byte reads 1.8V rail
// - Cache sleep upper byte reads 2.5V rail
// - Larger DAC code gives lower voltage
// - Cache below core: both follow cache code
// - Run pair and sleep pair compared separately
// - Override releases once cache reaches core
// - Override never alters stored codes
// - Voltage writes need unlock key first
// - Init register shares the same lock
// - Transfer timing selects clock source hand-over
// - Clock source field forwarded to test chip
// - Bits 5:4 drive bus ratio select
// - Unlocked only while key equals A05F
// - Lock bit 16 reads one when locked
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps

module voltage_and_init_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [vcfg_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [vcfg_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [vcfg_pkg::DATA_W-1:0] hrdata,
  output logic hresp,
  // Monitoring ADC samples (asynchronous)
  input wire logic [7:0] adc_core_run,
  input wire logic [7:0] adc_cache_run,
  input wire logic [7:0] adc_rail_1v8,
  input wire logic [7:0] adc_rail_2v5,
  // Regulator DAC codes
  output logic [7:0] core_run_dac,
  output logic [7:0] cache_run_dac,
  output logic [7:0] core_sleep_dac,
  output logic [7:0] cache_sleep_dac,
  // Test chip configuration
  input wire logic pll_input_clock,
  input wire logic reset_event,
  output logic [3:0] core_clock_source_select,
  output logic [1:0] bus_ratio_select
);
  import vcfg_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic hreadyout_ff;           // Low only in the first read data cycle
  logic [31:0] hrdata_ff;       // Registered read data
  logic hresp_ff;               // Always OKAY
  logic wr_pend_ff;             // Write data phase in progress
  logic rd_pend_ff;             // Read data phase, first cycle
  logic [31:0] addr_ff;         // Address captured in address phase
  logic [15:0] guard_key_value_ff; // Last key written to the lock register
  logic locked;                 // Bank closed to protected writes
  logic [7:0] core_run_code_ff, cache_run_code_ff, core_sleep_code_ff, cache_sleep_code_ff; // Stored codes
  xfer_mode_t xfer_mode_ff;     // Stored transfer timing
  logic [3:0] clksrc_ff;        // Stored clock source request
  logic [1:0] ratio_ff;         // Stored bus ratio
  logic [31:0] adc_meta_ff;     // Sync stage one, read by stage two only
  logic [31:0] adc_sync_ff;     // Sampled ADC bytes: core run, cache run, 1v8, 2v5
  logic pll_meta_ff, pll_sync_ff, pll_last_ff; // PLL pin sync and edge history
  logic rst_evt_meta_ff, rst_evt_sync_ff, rst_evt_last_ff; // Reset event sync and edge history
  logic [7:0] core_run_dac_ff, cache_run_dac_ff, core_sleep_dac_ff, cache_sleep_dac_ff; // DAC outputs
  logic [3:0] clksrc_out_ff;
  logic [1:0] ratio_out_ff;
  logic take;                   // Address phase accepted
  logic prot_wr;                // Protected write allowed this cycle
  logic [7:0] nxt_core_run_dac;
  logic [7:0] nxt_core_sleep_dac;
  logic nxt_clksrc_load;
  logic [31:0] nxt_hrdata;

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;
  assign core_run_dac = core_run_dac_ff;
  assign cache_run_dac = cache_run_dac_ff;
  assign core_sleep_dac = core_sleep_dac_ff;
  assign cache_sleep_dac = cache_sleep_dac_ff;
  assign core_clock_source_select = clksrc_out_ff;
  assign bus_ratio_select = ratio_out_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Only NONSEQ singles are used; SEQ is treated the same, IDLE and BUSY are ignored
  assign take = hsel && htrans[1] && hready;

  // Phase tracking; reads get one wait state so a write just before is always seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      hreadyout_ff <= !(take && !hwrite);
      if (take) begin
        addr_ff <= haddr;
      end
    end
  end

  // Response is never an error, unmapped addresses included
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hresp_ff <= HRESP_OKAY;
    end else begin
      hresp_ff <= HRESP_OKAY;
    end
  end

  // Read mux; unused bits and unmapped addresses read zero
  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    case (addr_ff)
      WRITE_GUARD_KEY_ADDR: begin
        nxt_hrdata[15:0] = guard_key_value_ff;
        nxt_hrdata[GUARD_LOCKED_BIT] = locked;
      end
      TEST_CHIP_INIT_CONFIG_ADDR: begin
        nxt_hrdata[XFER_LSB+:2] = xfer_mode_ff;
        nxt_hrdata[CLKSRC_LSB+:4] = clksrc_ff;
        nxt_hrdata[RATIO_LSB+:2] = ratio_ff;
      end
      CORE_RUN_VOLTAGE_CTRL_ADDR: begin
        nxt_hrdata[15:0] = {adc_sync_ff[31:24], core_run_code_ff};
      end
      CACHE_RUN_VOLTAGE_CTRL_ADDR: begin
        nxt_hrdata[15:0] = {adc_sync_ff[23:16], cache_run_code_ff};
      end
      CORE_SLEEP_VOLTAGE_CTRL_ADDR: begin
        nxt_hrdata[15:0] = {adc_sync_ff[15:8], core_sleep_code_ff};
      end
      CACHE_SLEEP_VOLTAGE_CTRL_ADDR: begin
        nxt_hrdata[15:0] = {adc_sync_ff[7:0], cache_sleep_code_ff};
      end
      default: nxt_hrdata = 32'h0000_0000;
    endcase
  end

  // Read data loaded in the wait cycle and held until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ****************************************************************
  // Write lock
  // ****************************************************************
  // Lock writes are always accepted; any value but the key closes the bank
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      guard_key_value_ff <= GUARD_KEY_RESET;
    end else if (wr_pend_ff && addr_ff == WRITE_GUARD_KEY_ADDR) begin
      guard_key_value_ff <= hwdata[15:0];
    end
  end

  assign locked = guard_key_value_ff != GUARD_UNLOCK_KEY;
  assign prot_wr = wr_pend_ff && !locked;

  // ****************************************************************
  // Voltage code registers
  // ****************************************************************
  // Stored codes; only the low byte is writable, locked writes are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_run_code_ff <= DAC_CODE_RESET;
      cache_run_code_ff <= DAC_CODE_RESET;
      core_sleep_code_ff <= DAC_CODE_RESET;
      cache_sleep_code_ff <= DAC_CODE_RESET;
    end else if (prot_wr) begin
      case (addr_ff)
        CORE_RUN_VOLTAGE_CTRL_ADDR: core_run_code_ff <= hwdata[DAC_LSB+:8];
        CACHE_RUN_VOLTAGE_CTRL_ADDR: cache_run_code_ff <= hwdata[DAC_LSB+:8];
        CORE_SLEEP_VOLTAGE_CTRL_ADDR: core_sleep_code_ff <= hwdata[DAC_LSB+:8];
        CACHE_SLEEP_VOLTAGE_CTRL_ADDR: cache_sleep_code_ff <= hwdata[DAC_LSB+:8];
        default: ;
      endcase
    end
  end

  // Larger code is lower voltage, so a larger cache code means the cache sits below the core
  always_comb begin
    nxt_core_run_dac = core_run_code_ff;
    nxt_core_sleep_dac = core_sleep_code_ff;
    if (cache_run_code_ff > core_run_code_ff) begin
      nxt_core_run_dac = cache_run_code_ff;
    end
    if (cache_sleep_code_ff > core_sleep_code_ff) begin
      nxt_core_sleep_dac = cache_sleep_code_ff;
    end
  end

  // DAC outputs; the override acts on the outputs only, never on the stored codes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_run_dac_ff <= DAC_CODE_RESET;
      cache_run_dac_ff <= DAC_CODE_RESET;
      core_sleep_dac_ff <= DAC_CODE_RESET;
      cache_sleep_dac_ff <= DAC_CODE_RESET;
    end else begin
      core_run_dac_ff <= nxt_core_run_dac;
      cache_run_dac_ff <= cache_run_code_ff;
      core_sleep_dac_ff <= nxt_core_sleep_dac;
      cache_sleep_dac_ff <= cache_sleep_code_ff;
    end
  end

  // ADC samples are only coherent if the converter holds them steady for several cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_meta_ff <= 32'h0000_0000;
      adc_sync_ff <= 32'h0000_0000;
    end else begin
      adc_meta_ff <= {adc_core_run, adc_cache_run, adc_rail_1v8, adc_rail_2v5};
      adc_sync_ff <= adc_meta_ff;
    end
  end

  // ****************************************************************
  // Initialisation register and test chip hand-over
  // ****************************************************************
  // Stored fields, guarded by the same lock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_mode_ff <= XFER_BUS_CLK;
      clksrc_ff <= CLKSRC_RESET;
      ratio_ff <= RATIO_RESET;
    end else if (prot_wr && addr_ff == TEST_CHIP_INIT_CONFIG_ADDR) begin
      xfer_mode_ff <= xfer_mode_t'(hwdata[XFER_LSB+:2]);
      clksrc_ff <= hwdata[CLKSRC_LSB+:4];
      ratio_ff <= hwdata[RATIO_LSB+:2];
    end
  end

  // PLL input clock and reset event come from pins; edges seen on the synchronised copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_meta_ff <= 1'b0;
      pll_sync_ff <= 1'b0;
      pll_last_ff <= 1'b0;
      rst_evt_meta_ff <= 1'b0;
      rst_evt_sync_ff <= 1'b0;
      rst_evt_last_ff <= 1'b0;
    end else begin
      pll_meta_ff <= pll_input_clock;
      pll_sync_ff <= pll_meta_ff;
      pll_last_ff <= pll_sync_ff;
      rst_evt_meta_ff <= reset_event;
      rst_evt_sync_ff <= rst_evt_meta_ff;
      rst_evt_last_ff <= rst_evt_sync_ff;
    end
  end

  // Moment at which the clock source request is passed on
  always_comb begin
    case (xfer_mode_ff)
      XFER_BUS_CLK: nxt_clksrc_load = 1'b1;
      XFER_NEXT_RESET: nxt_clksrc_load = rst_evt_sync_ff && !rst_evt_last_ff;
      XFER_PLL_RISE: nxt_clksrc_load = pll_sync_ff && !pll_last_ff;
      XFER_PLL_FALL: nxt_clksrc_load = !pll_sync_ff && pll_last_ff;
      default: nxt_clksrc_load = 1'b0;
    endcase
  end

  // Test chip outputs; reserved codes are forwarded unchanged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clksrc_out_ff <= CLKSRC_RESET;
      ratio_out_ff <= RATIO_RESET;
    end else begin
      ratio_out_ff <= ratio_ff;
      if (nxt_clksrc_load) begin
        clksrc_out_ff <= clksrc_ff;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_done;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait;
    s_rd_take |=> s_rd_done;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read not answered after one wait");
  property p_run_protect;
    (cache_run_code_ff > core_run_code_ff) |=> core_run_dac == $past(cache_run_code_ff);
  endproperty
  a_run_protect: assert property (p_run_protect) else $error("run core not clamped to cache");
  property p_run_release;
    (cache_run_code_ff <= core_run_code_ff) |=> core_run_dac == $past(core_run_code_ff);
  endproperty
  a_run_release: assert property (p_run_release) else $error("run core not following own code");
  property p_sleep_pair;
    (cache_sleep_code_ff > core_sleep_code_ff) && (cache_run_code_ff <= core_run_code_ff)
      |=> core_sleep_dac == $past(cache_sleep_code_ff) && core_run_dac == $past(core_run_code_ff);
  endproperty
  a_sleep_pair: assert property (p_sleep_pair) else $error("pairs not compared separately");
  property p_locked_drop;
    wr_pend_ff && locked && addr_ff == CORE_RUN_VOLTAGE_CTRL_ADDR |=> $stable(core_run_code_ff);
  endproperty
  a_locked_drop: assert property (p_locked_drop) else $error("locked write changed a code");
  property p_unlocked_write;
    prot_wr && addr_ff == CACHE_SLEEP_VOLTAGE_CTRL_ADDR |=> cache_sleep_code_ff == $past(hwdata[7:0]);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked write not stored");
  property p_key_opens;
    wr_pend_ff && addr_ff == WRITE_GUARD_KEY_ADDR |=> locked == ($past(hwdata[15:0]) != GUARD_UNLOCK_KEY);
  endproperty
  a_key_opens: assert property (p_key_opens) else $error("lock state wrong after key write");
  property p_lock_read;
    rd_pend_ff && addr_ff == WRITE_GUARD_KEY_ADDR |=> hrdata[16] == $past(locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit reads wrong");
  property p_adc_read;
    rd_pend_ff && addr_ff == CORE_SLEEP_VOLTAGE_CTRL_ADDR
      |=> hrdata[15:8] == $past(adc_sync_ff[15:8]) && hrdata[7:0] == $past(core_sleep_code_ff);
  endproperty
  a_adc_read: assert property (p_adc_read) else $error("sleep register read wrong");
  property p_init_lock;
    wr_pend_ff && locked && addr_ff == TEST_CHIP_INIT_CONFIG_ADDR |=> $stable(clksrc_ff) && $stable(ratio_ff);
  endproperty
  a_init_lock: assert property (p_init_lock) else $error("locked init write took effect");
  property p_clksrc_bus;
    xfer_mode_ff == XFER_BUS_CLK |=> core_clock_source_select == $past(clksrc_ff);
  endproperty
  a_clksrc_bus: assert property (p_clksrc_bus) else $error("clock source not passed on bus clock");
  property p_clksrc_defer;
    xfer_mode_ff == XFER_NEXT_RESET && !(rst_evt_sync_ff && !rst_evt_last_ff)
      |=> $stable(core_clock_source_select);
  endproperty
  a_clksrc_defer: assert property (p_clksrc_defer) else $error("deferred source moved early");
  property p_ratio;
    ##1 bus_ratio_select == $past(ratio_ff, 1);
  endproperty
  a_ratio: assert property (p_ratio) else $error("bus ratio not forwarded");
endmodule : voltage_and_init_config_regs

// File: tb/vcfg_far_side.sv
// Far-side model: monitoring ADC samples, test-chip PLL input clock and reset event pin.
// Assumes the bench bus clock; every pin changes only just after a rising clock edge.
`timescale 1ns/1ps

module vcfg_far_side #(
  parameter logic [7:0] CORE_ADC = 8'h4b,
  parameter logic [7:0] CACHE_ADC = 8'h5c,
  parameter logic [7:0] R18_ADC = 8'he1,
  parameter logic [7:0] R25_ADC = 8'h9c
) (
  // Bench control
  input wire logic clk,
  input wire logic pll_on,
  input wire logic rev_go,
  // ADC samples
  output logic [7:0] adc_core_run,
  output logic [7:0] adc_cache_run,
  output logic [7:0] adc_rail_1v8,
  output logic [7:0] adc_rail_2v5,
  // Test chip pins
  output logic pll_input_clock,
  output logic reset_event
);
  logic [1:0] div_ff = 2'h0; // Half period counter

  // ADC samples are steady levels, far longer than the sync needs
  assign adc_core_run = CORE_ADC;
  assign adc_cache_run = CACHE_ADC;
  assign adc_rail_1v8 = R18_ADC;
  assign adc_rail_2v5 = R25_ADC;

  initial pll_input_clock = 1'b0;
  initial reset_event = 1'b0;

  // PLL clock stands low unless enabled; a half period of four cycles clears the synchroniser
  always @(posedge clk) begin
    div_ff <= pll_on ? div_ff + 2'h1 : 2'h0;
    if (!pll_on) begin
      pll_input_clock <= 1'b0;
    end else if (div_ff == 2'h3) begin
      pll_input_clock <= ~pll_input_clock;
    end
  end

  // Reset event pin follows the bench request one cycle late
  always @(posedge clk) reset_event <= rev_go;
endmodule : vcfg_far_side

// File: tb/voltage_and_init_config_regs_bench.sv
// Bench for the voltage and init register bank: AHB-Lite register tasks and directed scenarios.
// Assumes one slave on the bus, so the slave's ready is fed back as hready.
`timescale 1ns/1ps

module voltage_and_init_config_regs_bench;
  import vcfg_pkg::*;
  localparam logic [7:0] ADC [4] = '{8'h4b, 8'h5c, 8'he1, 8'h9c};
  localparam logic [7:0] CODE [4] = '{8'h60, 8'h70, 8'h90, 8'h88};
  localparam logic [31:0] AV [4] = '{CORE_RUN_VOLTAGE_CTRL_ADDR, CACHE_RUN_VOLTAGE_CTRL_ADDR,
    CORE_SLEEP_VOLTAGE_CTRL_ADDR, CACHE_SLEEP_VOLTAGE_CTRL_ADDR};
  localparam logic [31:0] A_LK = WRITE_GUARD_KEY_ADDR;
  localparam logic [31:0] A_IN = TEST_CHIP_INIT_CONFIG_ADDR;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, pll_on = 1'b0, rev_go = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0, rsel;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, pll, rev;
  logic [7:0] a0, a1, a2, a3, d0, d1, d2, d3;
  logic [3:0] csel;
  int fails = 0, n_compared = 0;

  always #25 clk = ~clk;

  vcfg_far_side #(.CORE_ADC(ADC[0]), .CACHE_ADC(ADC[1]), .R18_ADC(ADC[2]), .R25_ADC(ADC[3])) far (
    .clk(clk), .pll_on(pll_on), .rev_go(rev_go), .adc_core_run(a0), .adc_cache_run(a1),
    .adc_rail_1v8(a2), .adc_rail_2v5(a3), .pll_input_clock(pll), .reset_event(rev));

  voltage_and_init_config_regs dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .adc_core_run(a0), .adc_cache_run(a1), .adc_rail_1v8(a2), .adc_rail_2v5(a3),
    .core_run_dac(d0), .cache_run_dac(d1), .core_sleep_dac(d2), .cache_sleep_dac(d3),
    .pll_input_clock(pll), .reset_event(rev), .core_clock_source_select(csel),
    .bus_ratio_select(rsel));

  // ****************************************************************
  // Check and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Bounded wait for hready high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      end_of_test;
    end
  endtask : wait_rdy

  // One single word transfer; read data lands in q
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : xfer

  task automatic rd(input logic [31:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Test chip outputs packed as {ratio, source}
  task automatic chk_tc(input logic [5:0] e);
    chk("testchip", {26'h0, rsel, csel}, {26'h0, e});
  endtask : chk_tc

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    cyc(5);
    rst_b <= 1'b1;
    cyc(1);
    // Reset state: locked, centre codes, bypassed PLL
    rd(A_LK); chk("lock", q, 32'h0001_0000);
    for (int i = 0; i < 4; i++) begin
      rd(AV[i]); chk("volt", q, {16'h0, ADC[i], DAC_CODE_RESET});
    end
    rd(A_IN); chk("init", q, 32'h0000_0300);
    chk("dac", {d0, d1, d2, d3}, 32'h8080_8080);
    chk_tc(6'h03);
    // Writes while locked vanish
    wr(AV[0], 32'h0000_0010);
    wr(A_IN, 32'h0000_0020);
    cyc(3);
    rd(AV[0]); chk("locked", {24'h0, q[7:0]}, 32'h0000_0080);
    rd(A_IN); chk("locked", q, 32'h0000_0300);
    // Unlock; upper key bits are not part of the key
    wr(A_LK, 32'hffff_a05f);
    rd(A_LK); chk("lock", q, 32'h0000_a05f);
    // Read-modify-write of each code; cache run code above core run code
    for (int i = 0; i < 4; i++) begin
      rd(AV[i]);
      wr(AV[i], {q[31:8], CODE[i]});
    end
    cyc(3);
    chk("dac", {d0, d1, d2, d3}, 32'h7070_9088);
    rd(AV[0]); chk("code", {24'h0, q[7:0]}, 32'h0000_0060);
    // Sleep pair now overridden on its own
    wr(AV[3], 32'hffff_ffa0);
    cyc(3);
    chk("dac", {d0, d1, d2, d3}, 32'h7070_a0a0);
    // Equal codes release the run override
    wr(AV[1], 32'h0000_0060);
    cyc(3);
    chk("dac", {d0, d1, d2, d3}, 32'h6060_a0a0);
    rd(AV[3]); chk("volt", q, {16'h0, ADC[3], 8'ha0});
    // Transfer mode 00: immediate
    wr(A_IN, 32'h0000_0020);
    cyc(3);
    chk_tc(6'h20);
    // Mode 01: source waits for the reset event, ratio does not
    wr(A_IN, 32'h0000_4310);
    cyc(3);
    chk_tc(6'h10);
    rev_go <= 1'b1;
    cyc(3);
    rev_go <= 1'b0;
    cyc(6);
    chk_tc(6'h13);
    // Mode 10: waits for a PLL clock rise
    wr(A_IN, 32'h0000_8030);
    cyc(3);
    chk_tc(6'h33);
    pll_on <= 1'b1;
    cyc(16);
    pll_on <= 1'b0;
    cyc(6);
    chk_tc(6'h30);
    // Mode 11: waits for a PLL clock fall
    wr(A_IN, 32'h0000_c300);
    cyc(3);
    chk_tc(6'h00);
    pll_on <= 1'b1;
    cyc(16);
    pll_on <= 1'b0;
    cyc(6);
    chk_tc(6'h03);
    rd(A_IN); chk("init", q, 32'h0000_c300);
    // Relock with another value, then a write must vanish
    wr(A_LK, 32'h0000_1234);
    rd(A_LK); chk("lock", q, 32'h0001_1234);
    wr(AV[2], 32'h0000_0011);
    rd(AV[2]); chk("locked", {24'h0, q[7:0]}, 32'h0000_0090);
    // Unmapped word reads zero
    rd(32'h1000_0090); chk("unmapped", q, 32'h0);
    end_of_test;
  end
endmodule : voltage_and_init_config_regs_bench
